// >>> common/ssw_pkg.sv
// Constants, register map and types of the supply supervisor watchdog.
package ssw_pkg;
  // Clock and watchdog timebase.
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_PERIOD_NS = 6_400_000;
  localparam int WD_HALF_PERIOD_NS = 3_200_000;
  localparam int HALF_TICK_CYCLES_DEF = WD_HALF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_PERIOD = WD_PERIOD_NS / WD_HALF_PERIOD_NS;
  localparam int EXT_SHIFT = 7;
  // Manual reset glitch rejection, least time, rounded up.
  localparam int MR_GLITCH_NS = 200;
  localparam int MR_FILT_CYCLES_DEF =
    (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLES_DEF = 64;
  // Field widths.
  localparam int SET_W = 16;
  localparam int CLS_W = 2;
  localparam int WDS_W = SET_W + CLS_W;
  localparam int CNT_W = SET_W + EXT_SHIFT + 2;
  // Watchdog timing setting classes.
  localparam logic [CLS_W-1:0] CLS_GROUNDED = 2'h0;
  localparam logic [CLS_W-1:0] CLS_SHORT = 2'h1;
  localparam logic [CLS_W-1:0] CLS_NORMAL = 2'h2;
  localparam logic [CLS_W-1:0] CLS_OPEN = 2'h3;
  // Register map, byte addresses.
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_RST_SET = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_WD_SET = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_WD_STORED = 12'h00C;
  localparam logic [SET_W-1:0] RST_SET_RESET = 16'h0002;
  localparam logic [WDS_W-1:0] WD_SET_RESET = 18'h2_0050;
  localparam int WD_CNT_LSB = 0;
  localparam int WD_CLS_LSB = 16;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_RST_BIT = 4;
  localparam int ST_MR_BIT = 5;
  localparam int ST_PF_BIT = 6;
  localparam int ST_VALID_BIT = 7;
  localparam int ST_FAULT_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    SSW_FAULT = 4'h1,
    SSW_HOLD = 4'h2,
    SSW_SAMPLE = 4'h4,
    SSW_RUN = 4'h8
  } ssw_state_t;
endpackage

// >>> common/ssw_reg_if.sv
// Register values passed between the bus slave and the supervisor core.
`timescale 1ns/1ps
interface ssw_reg_if;
  import ssw_pkg::*;
  logic [SET_W-1:0] rst_setting;
  logic [WDS_W-1:0] wd_setting;
  logic [31:0] status;
  logic [31:0] wd_stored;
  logic fault_clr;
  modport regs(output rst_setting, output wd_setting, output fault_clr,
               input status, input wd_stored);
  modport core(input rst_setting, input wd_setting, input fault_clr,
               output status, output wd_stored);
endinterface

// >>> verilog/ssw_axil_regs.sv
// AXI4-Lite register slave of the supply supervisor watchdog.
`timescale 1ns/1ps
module ssw_axil_regs
  import ssw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ssw_reg_if.regs rif
);
  logic aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [SET_W-1:0] rst_set_reg;
  logic [WDS_W-1:0] wd_set_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic [31:0] rst_merged;
  logic [31:0] wd_merged;

  // Bit 2 flags a mapped word, bits 1:0 give its index.
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    decode = {a[ADDR_W-1:4] == '0, a[3:2]};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = (aw_full_reg || aw_take) && (w_full_reg || w_take);
  assign wa = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
  assign wdat = w_full_reg ? w_data_reg : s_axi_wdata;
  assign wstb = w_full_reg ? w_strb_reg : s_axi_wstrb;
  assign wsel = decode(wa);
  assign rsel = decode(s_axi_araddr);
  assign rst_merged = merge({16'h0000, rst_set_reg}, wdat, wstb);
  assign wd_merged = merge({14'h0000, wd_set_reg}, wdat, wstb);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rif.rst_setting = rst_set_reg;
  assign rif.wd_setting = wd_set_reg;
  assign rif.fault_clr = do_write && wsel == {1'b1, ADDR_STATUS[3:2]} &&
                         wstb[ST_FAULT_BIT/8] && wdat[ST_FAULT_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_full_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (w_take) begin
          w_full_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_set_reg <= RST_SET_RESET;
      wd_set_reg <= WD_SET_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wsel[2] ? RESP_OKAY : RESP_SLVERR;
        if (wsel == {1'b1, ADDR_RST_SET[3:2]}) begin
          rst_set_reg <= rst_merged[SET_W-1:0];
        end
        if (wsel == {1'b1, ADDR_WD_SET[3:2]}) begin
          wd_set_reg <= wd_merged[WDS_W-1:0];
        end
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rsel[2] ? RESP_OKAY : RESP_SLVERR;
      unique case (rsel)
        {1'b1, ADDR_RST_SET[3:2]}: rdata_reg <= {16'h0000, rst_set_reg};
        {1'b1, ADDR_WD_SET[3:2]}: rdata_reg <= {14'h0000, wd_set_reg};
        {1'b1, ADDR_STATUS[3:2]}: rdata_reg <= rif.status;
        {1'b1, ADDR_WD_STORED[3:2]}: rdata_reg <= rif.wd_stored;
        default: rdata_reg <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule

// >>> verilog/ssw_supervisor.sv
// Supply supervisor with reset hold timer and watchdog, top level.
`timescale 1ns/1ps
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int HALF_TICK_CYCLES = HALF_TICK_CYCLES_DEF,
  parameter int MR_FILT_CYCLES = MR_FILT_CYCLES_DEF,
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supply_below_threshold,
  input wire logic supply_above_hysteresis,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_range_select,
  output logic reset_out_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NPIN = 5;
  localparam int HW = $clog2(HALF_TICK_CYCLES + 1);
  localparam int MW = $clog2(MR_FILT_CYCLES + 1);
  localparam int SW = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(HALF_TICK_CYCLES - 1);
  localparam logic [MW-1:0] MR_LAST = MW'(MR_FILT_CYCLES - 1);
  localparam logic [SW-1:0] SMP_LAST = SW'(SAMPLE_CYCLES - 1);
  localparam int HOLD_W = SET_W + 2;

  ssw_reg_if rif();

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic s_below;
  logic s_above;
  logic s_mr_n;
  logic s_kick;
  logic s_range;
  logic mr_filt_reg;
  logic [MW-1:0] mr_cnt_reg;
  logic pf_reg;
  logic kick_prev_reg;
  logic range_prev_reg;
  logic kick_fall;
  logic range_edge;
  logic cond_active;
  ssw_state_t state_reg;
  ssw_state_t state_next;
  logic [HW-1:0] half_cnt_reg;
  logic half_tick;
  logic div_clr;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic [HOLD_W-1:0] hold_target;
  logic hold_done;
  logic [SW-1:0] smp_cnt_reg;
  logic smp_done;
  logic [WDS_W-1:0] wd_stored_reg;
  logic wd_valid_reg;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [CNT_W-1:0] wd_periods;
  logic [CNT_W-1:0] wd_limit;
  logic [CLS_W-1:0] wd_cls;
  logic expire;
  logic fault_seen_reg;
  logic reset_out_n_reg;

  ssw_axil_regs u_regs (
    .clk(clk),
    .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif)
  );

  // The manual reset pin has no pull-up; the board must drive it.
  assign pin_raw = {watchdog_range_select, watchdog_kick_in,
                    manual_reset_in_n, supply_above_hysteresis,
                    supply_below_threshold};

  // Synchronisers clear to 0, so manual reset reads as pressed and
  // holds reset until the real pin level has passed the filter.
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= pin_raw[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end

  assign s_below = sync2_reg[0];
  assign s_above = sync2_reg[1];
  assign s_mr_n = sync2_reg[2];
  assign s_kick = sync2_reg[3];
  assign s_range = sync2_reg[4];

  // A new level is adopted only after it has stood unbroken.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mr_filt_reg <= 1'b0;
      mr_cnt_reg <= '0;
    end else if (s_mr_n == mr_filt_reg) begin
      mr_cnt_reg <= '0;
    end else if (mr_cnt_reg == MR_LAST) begin
      mr_filt_reg <= s_mr_n;
      mr_cnt_reg <= '0;
    end else begin
      mr_cnt_reg <= mr_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pf_reg <= 1'b1;
    end else if (s_below) begin
      pf_reg <= 1'b1;
    end else if (s_above) begin
      pf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kick_prev_reg <= 1'b0;
      range_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= s_kick;
      range_prev_reg <= s_range;
    end
  end

  assign kick_fall = kick_prev_reg && !s_kick;
  assign range_edge = range_prev_reg != s_range;
  assign cond_active = pf_reg || !mr_filt_reg;

  // Divider restarts with each hold, sample or watchdog clear.
  assign div_clr = state_reg == SSW_FAULT || state_reg == SSW_SAMPLE ||
                   expire || (state_reg == SSW_RUN &&
                   (kick_fall || range_edge));
  assign half_tick = half_cnt_reg == HALF_LAST;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt_reg <= '0;
    end else if (div_clr || half_tick) begin
      half_cnt_reg <= '0;
    end else begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end
  end

  // Hold time is the reset setting in whole watchdog periods.
  assign hold_target = HOLD_W'(rif.rst_setting) *
                       HOLD_W'(TICKS_PER_PERIOD);
  assign hold_done = hold_cnt_reg >= hold_target;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_reg <= '0;
    end else if (state_reg != SSW_HOLD) begin
      hold_cnt_reg <= '0;
    end else if (half_tick && !hold_done) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  assign smp_done = smp_cnt_reg == SMP_LAST;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smp_cnt_reg <= '0;
    end else if (state_reg != SSW_SAMPLE || smp_done) begin
      smp_cnt_reg <= '0;
    end else begin
      smp_cnt_reg <= smp_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_stored_reg <= '0;
      wd_valid_reg <= 1'b0;
    end else if (state_reg == SSW_SAMPLE && smp_done &&
                 !cond_active) begin
      wd_stored_reg <= rif.wd_setting;
      wd_valid_reg <= 1'b1;
    end
  end

  // Timeout in half periods: 2 * periods + 1, periods scaled by range.
  assign wd_cls = wd_stored_reg[WD_CLS_LSB +: CLS_W];
  assign wd_periods = s_range ?
                      CNT_W'(wd_stored_reg[WD_CNT_LSB +: SET_W]) <<
                      EXT_SHIFT :
                      CNT_W'(wd_stored_reg[WD_CNT_LSB +: SET_W]);
  assign wd_limit = CNT_W'(wd_periods * CNT_W'(TICKS_PER_PERIOD)) +
                    CNT_W'(1);
  assign expire = state_reg == SSW_RUN && !range_edge && !kick_fall &&
                  (wd_cls == CLS_SHORT ||
                  (wd_cls == CLS_NORMAL && wd_cnt_reg >= wd_limit));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_reg <= '0;
    end else if (state_reg != SSW_RUN || kick_fall || range_edge ||
                 expire) begin
      wd_cnt_reg <= '0;
    end else if (half_tick && wd_cnt_reg < wd_limit) begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    if (cond_active) begin
      state_next = SSW_FAULT;
    end else begin
      unique case (state_reg)
        SSW_FAULT: state_next = SSW_HOLD;
        SSW_HOLD: if (hold_done) begin
          state_next = SSW_SAMPLE;
        end
        SSW_SAMPLE: if (smp_done) begin
          state_next = SSW_RUN;
        end
        SSW_RUN: if (expire) begin
          state_next = SSW_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SSW_FAULT;
      reset_out_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      reset_out_n_reg <= state_next == SSW_SAMPLE ||
                         state_next == SSW_RUN;
    end
  end

  // A new expiry in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_seen_reg <= 1'b0;
    end else if (expire) begin
      fault_seen_reg <= 1'b1;
    end else if (rif.fault_clr) begin
      fault_seen_reg <= 1'b0;
    end
  end

  assign reset_out_n = reset_out_n_reg;
  assign rif.wd_stored = {14'h0000, wd_stored_reg};
  assign rif.status = {23'h00_0000, fault_seen_reg, wd_valid_reg, pf_reg,
                       mr_filt_reg, reset_out_n_reg, state_reg};

  fault_low_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    cond_active |=> !reset_out_n && state_reg == SSW_FAULT)
    else $error("reset not asserted under a reset condition");

  hold_release_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(reset_out_n) |-> $past(state_reg) == SSW_HOLD &&
    $past(hold_done) && $past(hold_cnt_reg) == $past(hold_target))
    else $error("reset released before the hold period ended");

  wd_pulse_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    expire && !cond_active |=> state_reg == SSW_HOLD && !reset_out_n &&
    hold_cnt_reg == '0)
    else $error("watchdog expiry did not start a hold pulse");

  wd_limit_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    expire && wd_cls == CLS_NORMAL |-> wd_cnt_reg == wd_limit &&
    wd_limit[0])
    else $error("watchdog expired at the wrong count");

  wd_range_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_range |-> wd_periods ==
    CNT_W'(wd_stored_reg[WD_CNT_LSB +: SET_W]) * CNT_W'(128))
    else $error("extended range scaling is wrong");

  wd_disable_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    wd_cls == CLS_GROUNDED || wd_cls == CLS_OPEN |-> !expire)
    else $error("disabled watchdog produced an expiry");

  wd_clear_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_reg == SSW_RUN && (kick_fall || range_edge) |=>
    wd_cnt_reg == '0 && half_cnt_reg == '0)
    else $error("kick or range change did not clear the watchdog");

  wd_idle_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    !reset_out_n ##1 !reset_out_n |-> wd_cnt_reg == '0)
    else $error("watchdog counted while reset was asserted");

  mr_filter_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    $changed(mr_filt_reg) |-> $past(mr_cnt_reg) == MR_LAST &&
    $past(s_mr_n) == mr_filt_reg)
    else $error("manual reset level adopted without filtering");

  mr_hold_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(mr_filt_reg) && !pf_reg |=> state_reg == SSW_HOLD)
    else $error("manual reset release did not start the hold");

  pf_release_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(pf_reg) |-> $past(s_above) && !$past(s_below))
    else $error("supply release without hysteresis level");

  sample_abort_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_reg == SSW_SAMPLE && cond_active |=>
    state_reg == SSW_FAULT && $stable(wd_stored_reg) ##1
    smp_cnt_reg == '0)
    else $error("sampling not abandoned on reset");

  tick_div_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    half_tick && !div_clr |=> half_cnt_reg == '0 ##1
    (half_cnt_reg == HW'(1) || $past(div_clr)))
    else $error("divider did not wrap at the half period");
endmodule

// >>> tb/ssw_cpu_model.sv
// Processor model that services the watchdog while out of reset.
`timescale 1ns/1ps
module ssw_cpu_model #(parameter int HALF = 4) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic kick_en,
  output logic kick
);
  int cnt = 0;
  initial kick = 1;
  always @(posedge clk) begin
    cnt <= (!reset_n || !kick_en || cnt == HALF - 1) ? 0 : cnt + 1;
    if (reset_n && kick_en && cnt == HALF - 1) kick <= !kick;
  end
endmodule

// >>> tb/supply_supervisor_watchdog_test.sv
// Self-checking testbench of the supply supervisor watchdog.
`timescale 1ns/1ps
module supply_supervisor_watchdog_test
  import ssw_pkg::*;
;
  logic clk = 0, arst_n = 0, supply_below_threshold = 0, kick_en = 1;
  logic supply_above_hysteresis = 1, watchdog_range_select = 0;
  logic manual_reset_in_n = 1;
  logic watchdog_kick_in, reset_out_n, s_axi_awready, s_axi_wready;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_bvalid;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int num_errors = 0, checks_done = 0, c;
  ssw_supervisor #(.HALF_TICK_CYCLES(8), .MR_FILT_CYCLES(3),
    .SAMPLE_CYCLES(8)) u_dut (.*);
  ssw_cpu_model #(.HALF(4)) u_cpu (.clk(clk), .reset_n(reset_out_n),
    .kick_en(kick_en), .kick(watchdog_kick_in));
  initial forever #5 clk = ~clk;
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %0h got %0h", n, e, g);
    end
  endtask
  // A count outside its window is reported against the nearer bound.
  task automatic chk_rng(string n, int g, int lo, int hi);
    chk(n, (g < lo) ? lo : (g > hi) ? hi : g, g);
  endtask
  task automatic timeout();
    num_errors++;
    stop_test();
  endtask
  task automatic wait_rst(logic lvl, int lim, bit must, output int k);
    k = 0;
    while (reset_out_n !== lvl && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (must && k == lim) timeout();
  endtask
  task automatic axi(bit wr, logic [11:0] a, logic [31:0] wd,
    output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      d = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 50) timeout();
  endtask
  task automatic press_button(int len);
    manual_reset_in_n <= 0;
    repeat (len) @(posedge clk);
    manual_reset_in_n <= 1;
  endtask
  // A supply drop inside the sampling window must leave the old copy.
  task automatic t_abort();
    axi(1, ADDR_WD_SET, 32'h0000_0001, rd, rs);
    press_button(10);
    wait_rst(1, 200, 1, c);
    supply_below_threshold <= 1;
    supply_above_hysteresis <= 0;
    repeat (8) @(posedge clk);
    axi(0, ADDR_WD_STORED, 0, rd, rs);
    chk("smp_abort", WD_SET_RESET, rd);
    supply_below_threshold <= 0;
    supply_above_hysteresis <= 1;
    wait_rst(1, 200, 1, c);
    repeat (12) @(posedge clk);
    axi(0, ADDR_WD_STORED, 0, rd, rs);
    chk("smp_redo", 32'h0000_0001, rd);
  endtask
  task automatic t_manual();
    press_button(20);
    wait_rst(1, 200, 1, c);
    chk_rng("man_hold", c, 48, 60);
    manual_reset_in_n <= 0;
    @(posedge clk);
    manual_reset_in_n <= 1;
    wait_rst(0, 20, 0, c);
    chk("man_glitch", 20, c);
  endtask
  task automatic t_supply();
    supply_below_threshold <= 1;
    supply_above_hysteresis <= 0;
    repeat (8) @(posedge clk);
    chk("pf_low", 0, reset_out_n);
    supply_below_threshold <= 0;
    wait_rst(1, 100, 0, c);
    chk("pf_hyst", 100, c);
    supply_above_hysteresis <= 1;
    wait_rst(1, 200, 1, c);
    chk_rng("pf_hold", c, 48, 60);
  endtask
  task automatic t_wdog();
    axi(1, ADDR_WD_SET, 32'h0002_0001, rd, rs);
    press_button(10);
    wait_rst(1, 200, 1, c);
    wait_rst(0, 300, 0, c);
    chk("kicked", 300, c);
    kick_en <= 0;
    wait_rst(0, 60, 1, c);
    wait_rst(1, 60, 1, c);
    chk_rng("wd_pulse", c, 48, 52);
    wait_rst(0, 60, 1, c);
    chk_rng("wd_normal", c, 18, 36);
    watchdog_range_select <= 1;
    wait_rst(1, 60, 1, c);
    wait_rst(0, 2200, 1, c);
    chk_rng("wd_ext", c, 2048, 2072);
    watchdog_range_select <= 0;
    wait_rst(1, 60, 1, c);
    repeat (16) @(posedge clk);
    watchdog_range_select <= 1;
    @(posedge clk);
    watchdog_range_select <= 0;
    wait_rst(0, 60, 1, c);
    chk_rng("wd_sel_clr", c + 17, 34, 52);
  endtask
  task automatic t_classes();
    logic [31:0] cls [3] = '{32'h0000_0001, 32'h0003_0001, 32'h0001_0001};
    axi(0, ADDR_STATUS, 0, rd, rs);
    chk("wd_sticky", 1, rd[ST_FAULT_BIT]);
    axi(1, ADDR_STATUS, 32'h0000_0100, rd, rs);
    axi(0, ADDR_STATUS, 0, rd, rs);
    chk("wd_sticky_clr", 0, rd[ST_FAULT_BIT]);
    for (int i = 0; i < 3; i++) begin
      axi(1, ADDR_WD_SET, cls[i], rd, rs);
      press_button(10);
      wait_rst(1, 200, 1, c);
      wait_rst(0, 300, 0, c);
      if (i < 2) begin
        chk("wd_off", 300, c);
      end else begin
        chk_rng("wd_zero", c, 8, 10);
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1;
    wait_rst(1, 300, 1, c);
    axi(0, ADDR_WD_SET, 0, rd, rs);
    chk("wd_set", WD_SET_RESET, rd);
    axi(0, 12'h010, 0, rd, rs);
    chk("bad_rresp", RESP_SLVERR, rs);
    axi(1, ADDR_RST_SET, 32'h0000_0003, rd, rs);
    chk("wr_bresp", RESP_OKAY, rs);
    t_abort();
    t_manual();
    t_supply();
    t_wdog();
    t_classes();
    stop_test();
  end
endmodule
